/* design/mib_pkg.sv */
/*
 * Shared constants and types for the port statistics counter bank.
 * Assumes one core clock and a host that reaches the bank through the
 * byte-wide indirect access registers.
 */
package mib_pkg;
    localparam int N_PORTS   = 3;
    localparam int N_DROP    = 6;
    localparam int MIB_NUM   = 32;
    localparam int CNT_W     = 30;
    localparam int DROP_W    = 16;
    localparam int LEN_W     = 11;
    localparam int OVF_BIT   = 31;
    localparam int VALID_BIT = 30;

    // host register offsets
    localparam logic [7:0] REG_CTRL  = 8'h79;
    localparam logic [7:0] REG_TRIG  = 8'h7a;
    localparam logic [7:0] REG_DATA3 = 8'h80;
    localparam logic [7:0] REG_DATA2 = 8'h81;
    localparam logic [7:0] REG_DATA1 = 8'h82;
    localparam logic [7:0] REG_DATA0 = 8'h83;

    // control codes selecting the counter tables
    localparam logic [7:0] CTRL_MIB_PORT = 8'h1c;
    localparam logic [7:0] CTRL_MIB_DROP = 8'h1d;

    // indirect address map
    localparam logic [7:0] PORT_ADDR_END = 8'h60;
    localparam logic [7:0] DROP_TX_BASE  = 8'h00;
    localparam logic [7:0] DROP_RX_BASE  = 8'h03;

    // per-port counter offsets
    localparam logic [4:0] OFF_RX_LO_OCT   = 5'h00;
    localparam logic [4:0] OFF_RX_HI_OCT   = 5'h01;
    localparam logic [4:0] OFF_RX_SHORT    = 5'h02;
    localparam logic [4:0] OFF_RX_BROKEN   = 5'h03;
    localparam logic [4:0] OFF_RX_LONG_OK  = 5'h04;
    localparam logic [4:0] OFF_RX_LONG_BAD = 5'h05;
    localparam logic [4:0] OFF_RX_BAD_SYM  = 5'h06;
    localparam logic [4:0] OFF_RX_CRC_FAIL = 5'h07;
    localparam logic [4:0] OFF_RX_MISALIGN = 5'h08;
    localparam logic [4:0] OFF_RX_MAC_CTRL = 5'h09;
    localparam logic [4:0] OFF_RX_PAUSE    = 5'h0a;
    localparam logic [4:0] OFF_RX_BCAST    = 5'h0b;
    localparam logic [4:0] OFF_RX_MCAST    = 5'h0c;
    localparam logic [4:0] OFF_RX_UCAST    = 5'h0d;
    localparam logic [4:0] OFF_RX_BIN_MIN  = 5'h0e;
    localparam logic [4:0] OFF_RX_BIN_1    = 5'h0f;
    localparam logic [4:0] OFF_RX_BIN_2    = 5'h10;
    localparam logic [4:0] OFF_RX_BIN_3    = 5'h11;
    localparam logic [4:0] OFF_RX_BIN_4    = 5'h12;
    localparam logic [4:0] OFF_RX_BIN_MAX  = 5'h13;
    localparam logic [4:0] OFF_TX_LO_OCT   = 5'h14;
    localparam logic [4:0] OFF_TX_HI_OCT   = 5'h15;
    localparam logic [4:0] OFF_TX_LATE     = 5'h16;
    localparam logic [4:0] OFF_TX_PAUSE    = 5'h17;
    localparam logic [4:0] OFF_TX_BCAST    = 5'h18;
    localparam logic [4:0] OFF_TX_MCAST    = 5'h19;
    localparam logic [4:0] OFF_TX_UCAST    = 5'h1a;
    localparam logic [4:0] OFF_TX_DEFER    = 5'h1b;
    localparam logic [4:0] OFF_TX_ALL_COLL = 5'h1c;
    localparam logic [4:0] OFF_TX_ABANDON  = 5'h1d;
    localparam logic [4:0] OFF_TX_ONE_RTRY = 5'h1e;
    localparam logic [4:0] OFF_TX_MULTI_RT = 5'h1f;

    // frame length limits
    localparam logic [LEN_W-1:0] LEN_MIN      = 11'h040;
    localparam logic [LEN_W-1:0] LEN_BIN1_TOP = 11'h07f;
    localparam logic [LEN_W-1:0] LEN_BIN2_TOP = 11'h0ff;
    localparam logic [LEN_W-1:0] LEN_BIN3_TOP = 11'h1ff;
    localparam logic [LEN_W-1:0] LEN_BIN4_TOP = 11'h3ff;
    localparam logic [LEN_W-1:0] LEN_MAX_STD  = 11'h5f2;
    localparam logic [LEN_W-1:0] LEN_MAX_LONG = 11'h600;

    // reset values
    localparam logic [CNT_W:0]    CNT_RESET  = 31'h0000_0000;
    localparam logic [DROP_W-1:0] DROP_RESET = 16'h0000;
    localparam logic [7:0]        REG_RESET  = 8'h00;
    localparam logic [31:0]       DATA_RESET = 32'h0000_0000;

    typedef logic [N_PORTS-1:0][LEN_W-1:0] port_len_t;

    typedef struct packed {
        logic [MIB_NUM-1:0][CNT_W:0] cnt;
    } bank_state_t;

    typedef struct packed {
        logic [7:0]                    ctrl;
        logic [7:0]                    trig;
        logic [31:0]                   data;
        logic [7:0]                    rdata;
        logic [N_DROP-1:0][DROP_W-1:0] drop;
    } top_state_t;
endpackage

/* design/mib_port_bank.sv */
/*
 * Thirty-two read-clear counters of one switch port.
 * Assumes increments arrive as one-cycle strobes with octet amounts alongside.
 */
module mib_port_bank
    import mib_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic [MIB_NUM-1:0]  inc,
    input  wire logic [LEN_W-1:0]    rx_octets,
    input  wire logic [LEN_W-1:0]    tx_octets,
    input  wire logic                rd_stb,
    input  wire logic [4:0]          rd_sel,
    output logic      [31:0]         rd_word
);
    import mib_pkg::*;

    bank_state_t st;
    bank_state_t next_st;

    function automatic logic [CNT_W-1:0] amount(input logic [4:0] k, input logic [LEN_W-1:0] rxo,
                                               input logic [LEN_W-1:0] txo);
        if (k == OFF_RX_LO_OCT || k == OFF_RX_HI_OCT)
            return CNT_W'(rxo);
        else if (k == OFF_TX_LO_OCT || k == OFF_TX_HI_OCT)
            return CNT_W'(txo);
        else
            return CNT_W'(1);
    endfunction

    always_comb begin
        logic [CNT_W:0] base;
        logic [CNT_W:0] sum;
        base = CNT_RESET;
        sum = CNT_RESET;
        next_st = st;
        for (int k = 0; k < MIB_NUM; k++) begin
            // clearing and counting in one step keeps events during a read
            base = (rd_stb && rd_sel == 5'(k)) ? CNT_RESET : st.cnt[k];
            sum = {1'b0, base[CNT_W-1:0]} + {1'b0, (inc[k] ? amount(5'(k), rx_octets, tx_octets) : CNT_W'(0))};
            next_st.cnt[k] = {base[CNT_W] | sum[CNT_W], sum[CNT_W-1:0]};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st.cnt <= '{default: CNT_RESET};
        end else begin
            st <= next_st;
        end
    end

    // flag bit 30 is always set in a latched word
    assign rd_word = {st.cnt[rd_sel][CNT_W], 1'b1, st.cnt[rd_sel][CNT_W-1:0]};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_CLEAR_ON_READ: assert property (rd_stb && !inc[rd_sel] |=> st.cnt[$past(rd_sel)] == CNT_RESET)
        else $error("counter not cleared after read");
    AST_OVF_STICKY: assert property (!rd_stb && st.cnt[3][CNT_W] |=> st.cnt[3][CNT_W])
        else $error("overflow flag dropped without a read");
    AST_COUNT_STEP: assert property (!rd_stb && inc[2] && st.cnt[2][CNT_W-1:0] != '1
                                     |=> st.cnt[2][CNT_W-1:0] == $past(st.cnt[2][CNT_W-1:0]) + 1'b1)
        else $error("event counter did not step by one");
    COV_OVERFLOW: cover property (st.cnt[2][CNT_W-1:0] == '1 && inc[2] ##1 st.cnt[2][CNT_W]);
endmodule

/* design/port_statistics_counters.sv */
/*
 * Statistics counter bank of a three-port switch, read through the
 * indirect control, trigger and data byte registers.
 * Assumes frame-end strobes and frame attributes from the port MACs,
 * all synchronous to ref_clk, at most one rx and one tx frame per port per cycle.
 */
module port_statistics_counters
    import mib_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   max_len_long,
    input  wire logic [N_PORTS-1:0]     rx_done,
    input  wire mib_pkg::port_len_t     rx_len,
    input  wire logic [N_PORTS-1:0]     rx_crc_ok,
    input  wire logic [N_PORTS-1:0]     rx_whole_bytes,
    input  wire logic [N_PORTS-1:0]     rx_symbol_err,
    input  wire logic [N_PORTS-1:0]     rx_high_prio,
    input  wire logic [N_PORTS-1:0]     rx_bcast,
    input  wire logic [N_PORTS-1:0]     rx_mcast,
    input  wire logic [N_PORTS-1:0]     rx_mac_ctrl,
    input  wire logic [N_PORTS-1:0]     rx_pause_match,
    input  wire logic [N_PORTS-1:0]     tx_done,
    input  wire mib_pkg::port_len_t     tx_len,
    input  wire logic [N_PORTS-1:0]     tx_ok,
    input  wire logic [N_PORTS-1:0]     tx_high_prio,
    input  wire logic [N_PORTS-1:0]     tx_bcast,
    input  wire logic [N_PORTS-1:0]     tx_mcast,
    input  wire logic [N_PORTS-1:0]     tx_pause,
    input  wire logic [N_PORTS-1:0]     tx_deferred,
    input  wire logic [N_PORTS-1:0]     tx_one_retry,
    input  wire logic [N_PORTS-1:0]     tx_multi_retry,
    input  wire logic [N_PORTS-1:0]     tx_late_coll,
    input  wire logic [N_PORTS-1:0]     tx_collision,
    input  wire logic [N_PORTS-1:0]     tx_abandoned,
    input  wire logic [N_PORTS-1:0]     tx_drop,
    input  wire logic [N_PORTS-1:0]     rx_drop
);
    import mib_pkg::*;

    top_state_t st;
    top_state_t next_st;

    logic [N_PORTS-1:0][MIB_NUM-1:0] port_inc;
    logic [N_PORTS-1:0][LEN_W-1:0]   rx_oct;
    logic [N_PORTS-1:0][LEN_W-1:0]   tx_oct;
    logic [N_PORTS-1:0][31:0]        bank_word;
    logic [N_PORTS-1:0]              bank_rd;
    logic [LEN_W-1:0]                max_len;

    function automatic logic [MIB_NUM-1:0] rx_classes(
        input logic [LEN_W-1:0] len,
        input logic [LEN_W-1:0] maxl,
        input logic             crc_ok,
        input logic             whole,
        input logic             sym,
        input logic             hi,
        input logic             bc,
        input logic             mc,
        input logic             ctl,
        input logic             pz
    );
        logic [MIB_NUM-1:0] m;
        logic               good;
        logic               legal;
        m = '0;
        good = crc_ok && whole && !sym;
        legal = len >= LEN_MIN && len <= maxl;
        if (hi)
            m[OFF_RX_HI_OCT] = 1'b1;
        else
            m[OFF_RX_LO_OCT] = 1'b1;
        if (len < LEN_MIN) begin
            if (good)
                m[OFF_RX_SHORT] = 1'b1;
            else
                m[OFF_RX_BROKEN] = 1'b1;
        end else if (len > maxl) begin
            if (good)
                m[OFF_RX_LONG_OK] = 1'b1;
            else
                m[OFF_RX_LONG_BAD] = 1'b1;
        end else if (sym) begin
            m[OFF_RX_BAD_SYM] = 1'b1;
        end else if (!crc_ok) begin
            if (whole)
                m[OFF_RX_CRC_FAIL] = 1'b1;
            else
                m[OFF_RX_MISALIGN] = 1'b1;
        end
        m[OFF_RX_MAC_CTRL] = ctl;
        m[OFF_RX_PAUSE] = ctl && pz && crc_ok && len >= LEN_MIN;
        if (good && legal) begin
            // a frame flagged both ways counts once, as broadcast
            m[OFF_RX_BCAST] = bc;
            m[OFF_RX_MCAST] = mc && !bc && !ctl;
            m[OFF_RX_UCAST] = !mc && !bc;
        end
        m[OFF_RX_BIN_MIN] = len == LEN_MIN;
        m[OFF_RX_BIN_1] = len > LEN_MIN && len <= LEN_BIN1_TOP;
        m[OFF_RX_BIN_2] = len > LEN_BIN1_TOP && len <= LEN_BIN2_TOP;
        m[OFF_RX_BIN_3] = len > LEN_BIN2_TOP && len <= LEN_BIN3_TOP;
        m[OFF_RX_BIN_4] = len > LEN_BIN3_TOP && len <= LEN_BIN4_TOP;
        m[OFF_RX_BIN_MAX] = len > LEN_BIN4_TOP && len <= maxl;
        return m;
    endfunction

    function automatic logic [MIB_NUM-1:0] tx_classes(
        input logic hi,
        input logic bc,
        input logic mc,
        input logic pz,
        input logic one,
        input logic multi
    );
        logic [MIB_NUM-1:0] m;
        m = '0;
        if (hi)
            m[OFF_TX_HI_OCT] = 1'b1;
        else
            m[OFF_TX_LO_OCT] = 1'b1;
        m[OFF_TX_PAUSE] = pz;
        m[OFF_TX_BCAST] = bc;
        m[OFF_TX_MCAST] = mc && !bc;
        m[OFF_TX_UCAST] = !mc && !bc;
        m[OFF_TX_ONE_RTRY] = one;
        m[OFF_TX_MULTI_RT] = multi && !one;
        return m;
    endfunction

    assign max_len = max_len_long ? LEN_MAX_LONG : LEN_MAX_STD;

    always_comb begin
        for (int p = 0; p < N_PORTS; p++) begin
            port_inc[p] = '0;
            if (rx_done[p])
                port_inc[p] = rx_classes(rx_len[p], max_len, rx_crc_ok[p], rx_whole_bytes[p],
                                         rx_symbol_err[p], rx_high_prio[p], rx_bcast[p], rx_mcast[p],
                                         rx_mac_ctrl[p], rx_pause_match[p]);
            // only good transmissions count octets and casts
            if (tx_done[p] && tx_ok[p])
                port_inc[p] = port_inc[p] | tx_classes(tx_high_prio[p], tx_bcast[p], tx_mcast[p],
                                                       tx_pause[p], tx_one_retry[p], tx_multi_retry[p]);
            port_inc[p][OFF_TX_DEFER] = tx_done[p] && tx_deferred[p];
            port_inc[p][OFF_TX_LATE] = tx_late_coll[p];
            port_inc[p][OFF_TX_ALL_COLL] = tx_collision[p];
            port_inc[p][OFF_TX_ABANDON] = tx_abandoned[p];
            rx_oct[p] = rx_len[p];
            tx_oct[p] = tx_len[p];
        end
    end

    for (genvar g = 0; g < N_PORTS; g++) begin : g_bank
        mib_port_bank u_bank (
            .ref_clk   (ref_clk),
            .resetn    (resetn),
            .inc       (port_inc[g]),
            .rx_octets (rx_oct[g]),
            .tx_octets (tx_oct[g]),
            .rd_stb    (bank_rd[g]),
            .rd_sel    (reg_wdata[4:0]),
            .rd_word   (bank_word[g])
        );
    end

    always_comb begin
        logic [1:0] port_sel;
        logic       fetch;
        port_sel = reg_wdata[6:5];
        fetch = reg_wr && reg_addr == REG_TRIG;
        next_st = st;
        bank_rd = '0;
        next_st.rdata = REG_RESET;
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:  next_st.rdata = st.ctrl;
                REG_TRIG:  next_st.rdata = st.trig;
                REG_DATA3: next_st.rdata = st.data[31:24];
                REG_DATA2: next_st.rdata = st.data[23:16];
                REG_DATA1: next_st.rdata = st.data[15:8];
                REG_DATA0: next_st.rdata = st.data[7:0];
                default:   next_st.rdata = REG_RESET;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:  next_st.ctrl = reg_wdata;
                REG_TRIG:  next_st.trig = reg_wdata;
                REG_DATA3: next_st.data[31:24] = reg_wdata;
                REG_DATA2: next_st.data[23:16] = reg_wdata;
                REG_DATA1: next_st.data[15:8] = reg_wdata;
                REG_DATA0: next_st.data[7:0] = reg_wdata;
                default:   next_st.ctrl = st.ctrl;
            endcase
        end
        for (int i = 0; i < N_PORTS; i++) begin
            // drop counters wrap silently; software tracks overflow
            if (tx_drop[i])
                next_st.drop[i] = st.drop[i] + 1'b1;
            if (rx_drop[i])
                next_st.drop[N_PORTS + i] = st.drop[N_PORTS + i] + 1'b1;
        end
        if (fetch && st.ctrl == CTRL_MIB_PORT) begin
            if (reg_wdata < PORT_ADDR_END) begin
                bank_rd[port_sel] = 1'b1;
                next_st.data = bank_word[port_sel];
            end else begin
                next_st.data = DATA_RESET;
            end
        end else if (fetch && st.ctrl == CTRL_MIB_DROP) begin
            if (reg_wdata < 8'(N_DROP))
                next_st.data = {16'h0000, st.drop[reg_wdata[2:0]]};
            else
                next_st.data = DATA_RESET;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st.ctrl <= REG_RESET;
            st.trig <= REG_RESET;
            st.data <= DATA_RESET;
            st.rdata <= REG_RESET;
            st.drop <= '{default: DROP_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_PORT_FETCH_VALID: assert property (reg_wr && reg_addr == REG_TRIG && st.ctrl == CTRL_MIB_PORT
                                           && reg_wdata < PORT_ADDR_END |=> st.data[VALID_BIT])
        else $error("fetched port counter not flagged valid");
    AST_DROP_FORMAT: assert property (reg_wr && reg_addr == REG_TRIG && st.ctrl == CTRL_MIB_DROP
                                      |=> st.data[31:16] == 16'h0000)
        else $error("drop counter word has upper bits set");
    AST_DROP_KEEP: assert property (reg_wr && reg_addr == REG_TRIG && st.ctrl == CTRL_MIB_DROP && !tx_drop[0]
                                    |=> st.drop[0] == $past(st.drop[0]))
        else $error("drop counter changed on access");
    AST_DROP_STEP: assert property (tx_drop[1] |=> st.drop[1] == $past(st.drop[1]) + 16'h0001)
        else $error("drop counter did not advance");
    AST_BIN_MIN: assert property (rx_done[0] && rx_len[0] == LEN_MIN |-> port_inc[0][OFF_RX_BIN_MIN]
                                  && !port_inc[0][OFF_RX_BIN_1])
        else $error("64 byte frame missed its bin");
    AST_OVERSIZE: assert property (rx_done[1] && rx_crc_ok[1] && rx_whole_bytes[1] && !rx_symbol_err[1]
                                   && rx_len[1] > max_len |-> port_inc[1][OFF_RX_LONG_OK]
                                   && !port_inc[1][OFF_RX_BIN_MAX])
        else $error("oversize frame miscounted");
    AST_CRC_SPLIT: assert property (port_inc[0][OFF_RX_CRC_FAIL] |-> rx_whole_bytes[0] && !rx_crc_ok[0]
                                    && !port_inc[0][OFF_RX_MISALIGN])
        else $error("crc error class wrong");
    AST_PAUSE_QUAL: assert property (port_inc[2][OFF_RX_PAUSE] |-> rx_mac_ctrl[2] && rx_crc_ok[2]
                                     && rx_len[2] >= LEN_MIN && port_inc[2][OFF_RX_MAC_CTRL])
        else $error("unqualified pause counted");
    AST_RDATA_BYTE: assert property (reg_rd && reg_addr == REG_DATA0 && !reg_wr
                                     |=> reg_rdata == $past(st.data[7:0]))
        else $error("data byte read back wrong");
    COV_PORT_FETCH: cover property (reg_wr && reg_addr == REG_CTRL && reg_wdata == CTRL_MIB_PORT
                                    ##[1:4] reg_wr && reg_addr == REG_TRIG);
    COV_DROP_FETCH: cover property (st.ctrl == CTRL_MIB_DROP && reg_wr && reg_addr == REG_TRIG);
    COV_READ_WITH_EVENT: cover property (|bank_rd && rx_done[0]);
endmodule

/* test/host_model.sv */
/*
 * Host model: drives the byte-wide register bus and fetches counters.
 * Assumes reg_rdata is valid for one cycle after the read strobe edge.
 */
module host_model
    import mib_pkg::*;
(
    input  wire logic       ref_clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    end
    // address inverted once released, so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #2;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge ref_clk) #2;
        {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) #2;
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge ref_clk) #2;
        {reg_addr, reg_rd} = {~a, 1'b0};
        d = reg_rdata;
    endtask
    task automatic fetch(input logic [7:0] c, input logic [7:0] t, output logic [31:0] w);
        w = 32'h0000_0000;
        wr(REG_CTRL, c);
        wr(REG_TRIG, t);
        for (int i = 0; i < 4 && (i == 0 || (c == CTRL_MIB_PORT && !w[VALID_BIT])); i++) begin
            if (c == CTRL_MIB_PORT) begin
                rd(REG_DATA3, w[31:24]);
                rd(REG_DATA2, w[23:16]);
            end
            rd(REG_DATA1, w[15:8]);
            rd(REG_DATA0, w[7:0]);
        end
    endtask
endmodule

/* test/port_statistics_counters_tb_top.sv */
/*
 * Testbench: frames and drop events in, counters fetched through the host model.
 * Assumes a 40 MHz core clock and the design's registered read data.
 */
module port_statistics_counters_tb_top
    import mib_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int p; logic [LEN_W-1:0] len; logic crc, hi, bc; logic [7:0] trig; logic [29:0] cnt;} row_t;
    logic ref_clk, resetn, reg_wr, reg_rd, max_len_long;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
    logic [31:0] w;
    logic [N_PORTS-1:0] rx_done, rx_crc_ok, rx_whole_bytes, rx_symbol_err, rx_high_prio, rx_bcast, rx_mcast;
    logic [N_PORTS-1:0] rx_mac_ctrl, rx_pause_match, tx_done, tx_ok, tx_high_prio, tx_bcast, tx_mcast;
    logic [N_PORTS-1:0] tx_pause, tx_deferred, tx_one_retry, tx_multi_retry, tx_late_coll, tx_collision;
    logic [N_PORTS-1:0] tx_abandoned, tx_drop, rx_drop;
    port_len_t rx_len, tx_len;
    int error_cnt = 0;
    int tests_run = 0;
    // port 0 frames pile up in the 64-byte bin until the last row reads it
    row_t rows [7] = '{
        '{0, 11'd64, 1'b1, 1'b0, 1'b0, 8'h00, 30'd64},
        '{1, 11'd100, 1'b1, 1'b1, 1'b0, 8'h21, 30'd100},
        '{2, 11'd200, 1'b0, 1'b0, 1'b0, 8'h47, 30'd1},
        '{0, 11'd1600, 1'b1, 1'b0, 1'b0, 8'h04, 30'd1},
        '{0, 11'd64, 1'b1, 1'b0, 1'b1, 8'h0b, 30'd1},
        '{0, 11'd1100, 1'b0, 1'b0, 1'b0, 8'h13, 30'd1},
        '{0, 11'd64, 1'b1, 1'b0, 1'b0, 8'h0e, 30'd3}};
    port_statistics_counters u_dut (.*);
    host_model u_host (.*);
    always #12.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic frame(input row_t r);
        @(posedge ref_clk) #2;
        {rx_done[r.p], rx_len[r.p], rx_crc_ok[r.p]} = {1'b1, r.len, r.crc};
        {rx_high_prio[r.p], rx_bcast[r.p]} = {r.hi, r.bc};
        @(posedge ref_clk) #2;
        rx_done[r.p] = 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        {rx_done, rx_crc_ok, rx_symbol_err, rx_high_prio, rx_bcast, rx_mcast, rx_mac_ctrl, rx_pause_match} = '0;
        {tx_done, tx_ok, tx_high_prio, tx_bcast, tx_mcast, tx_pause, tx_deferred, tx_one_retry} = '0;
        {tx_multi_retry, tx_late_coll, tx_collision, tx_abandoned, tx_drop, rx_drop, rx_len, tx_len} = '0;
        {ref_clk, resetn, max_len_long, rx_whole_bytes} = {3'b000, 3'b111};
        repeat (3) @(posedge ref_clk);
        #2 resetn = 1'b1;
        u_host.rd(REG_DATA3, b);
        chk({24'h0, b}, 32'h0000_0000);
        $display("reset test done");
        foreach (rows[i]) begin
            frame(rows[i]);
            u_host.fetch(CTRL_MIB_PORT, rows[i].trig, w);
            chk(w, {2'b01, rows[i].cnt});
            $display("row %0d done", i);
        end
        u_host.fetch(CTRL_MIB_PORT, 8'h0e, w);
        chk(w, 32'h4000_0000);
        // long limit: 1530 bytes lands in the top bin, not oversize
        max_len_long = 1'b1;
        frame('{0, 11'd1530, 1'b1, 1'b0, 1'b0, 8'h13, 30'd1});
        max_len_long = 1'b0;
        u_host.fetch(CTRL_MIB_PORT, 8'h13, w);
        chk(w, 32'h4000_0001);
        {rx_mac_ctrl[2], rx_pause_match[2]} = 2'b11;
        frame('{2, 11'd64, 1'b1, 1'b0, 1'b0, 8'h4a, 30'd1});
        {rx_mac_ctrl[2], rx_pause_match[2]} = 2'b00;
        u_host.fetch(CTRL_MIB_PORT, 8'h4a, w);
        chk(w, 32'h4000_0001);
        u_host.fetch(CTRL_MIB_PORT, 8'h49, w);
        chk(w, 32'h4000_0001);
        $display("long limit and pause tests done");
        @(posedge ref_clk) #2;
        {tx_done[0], tx_ok[0], tx_len[0], tx_drop[2], rx_drop[0]} = {2'b11, 11'd80, 2'b11};
        @(posedge ref_clk) #2;
        tx_done[0] = 1'b0;
        @(posedge ref_clk) #2;
        {tx_drop[2], rx_drop[0]} = 2'b00;
        u_host.fetch(CTRL_MIB_PORT, 8'h14, w);
        chk(w, 32'h4000_0050);
        u_host.fetch(CTRL_MIB_DROP, 8'h02, w);
        chk(w, 32'h0000_0002);
        u_host.rd(REG_DATA3, b);
        chk({24'h0, b}, 32'h0000_0000);
        u_host.fetch(CTRL_MIB_DROP, 8'h03, w);
        chk(w, 32'h0000_0002);
        u_host.fetch(CTRL_MIB_DROP, 8'h03, w);
        chk(w, 32'h0000_0002);
        u_host.rd(8'h55, b);
        chk({24'h0, b}, 32'h0000_0000);
        $display("tx, drop and unmapped tests done");
        tally_and_finish();
    end
endmodule
